// ### rtl/arc_pkg.sv
// Constants for the result computation unit
package arc_pkg;
   localparam int ACC_W = 24;
   localparam int RES_W = 16;
   localparam logic [23:0] SUM_LIMIT = 24'h03ffff;
   localparam logic [3:0] A_CTRL2 = 4'h0;
   localparam logic [3:0] A_CTRL3 = 4'h1;
   localparam logic [3:0] A_STAT = 4'h2;
   localparam logic [3:0] A_RPT = 4'h3;
   localparam logic [3:0] A_CNT = 4'h4;
   localparam logic [3:0] A_SUMU = 4'h5;
   localparam logic [3:0] A_SUMH = 4'h6;
   localparam logic [3:0] A_SUML = 4'h7;
   localparam logic [3:0] A_FLT = 4'h8;
   localparam logic [3:0] A_UTH = 4'h9;
   localparam logic [3:0] A_LTH = 4'ha;
   localparam logic [3:0] A_SETP = 4'hb;
   localparam logic [3:0] A_ERR = 4'hc;
   localparam logic [3:0] A_CVD = 4'hd;
   localparam int CLR_BIT = 7;
   localparam int GO_BIT = 8;
   localparam int CLR_CYCLES = 5;
   localparam logic [2:0] MD_BASIC = 3'h0;
   localparam logic [2:0] MD_ACCUM = 3'h1;
   localparam logic [2:0] MD_AVG = 3'h2;
   localparam logic [2:0] MD_BURST = 3'h3;
   localparam logic [2:0] MD_LPF = 3'h4;
endpackage : arc_pkg

// ### rtl/arc_unit.sv
// Converter result computation unit with Avalon-MM register slave
//
// Function
// [R1] Running sum is 24 bits wide and sign-extended.
// [R2] Each trigger, software or external, adds the new result.
// [R3] Sum above 262143 sets the sum wrap flag.
// [R4] Each added sample increments the sample count.
// [R5] Sum clear bit clears sum, wrap flag and count, then self-clears.
// [R6] The clear takes five converter clock cycles.
// [R7] Shift amount right-shifts the sum to scale, average or filter.
// [R8] Mode 000: no accumulation, threshold comparison still runs.
// [R9] Mode 001: add, count, copy shifted sum, compare on sum.
// [R10] Mode 010: as 001 but compare only when count reaches target (code compares once count reaches target minus one).
// [R11] Mode 011: as average, and retrigger until count reaches target.
// [R12] Mode 100: low-pass filter; count keeps running past the target.
// [R13] Shift 1..7 sets filter cut-off from 0.72 to 0.0078 rad.
// [R14] Results are latched at end of computation for evaluation.
// [R15] Error select picks one of six error sources.
// [R16] Error compared to upper and lower thresholds sets two flags.
// [R17] Threshold mode chooses one of eight interrupt conditions.
// [R18] Selected condition true sets the threshold interrupt flag.
// [R19] All threshold comparisons are signed.
// [R20] Sum wrap flag set also signals the threshold interrupt.
// [R21] Sum readable and writable as three bytes, top holds 17:16.
// [R22] Software should set repeat target to two to the shift amount.
// [R23] Threshold conditions encoded 000 to 111 in listed order.
// [R24] Mode codes 101 to 111 behave as basic mode.
`timescale 1ns/1ps
`default_nettype none
module arc_unit #(
   parameter int RES_W = arc_pkg::RES_W
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic [3:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire logic              result_valid,
   input  wire logic [RES_W-1:0]  result,
   input  wire logic              ext_trigger,
   output logic                   conv_start,
   output logic                   threshold_irq
);
   typedef enum logic [1:0] {ARC_IDLE, ARC_CALC, ARC_CLEAR} arc_state_e;
   arc_state_e        state_q;
   // Datapath and register fields
   logic [23:0]       running_sum_q;
   logic [15:0]       sample_count_q;
   logic [7:0]        repeat_target_q;
   logic [2:0]        compute_mode_q;
   logic [2:0]        shift_amount_q;
   logic              sum_clear_bit_q;
   logic              cont_q;
   logic [2:0]        error_source_select_q;
   logic [2:0]        threshold_mode_select_q;
   logic [15:0]       upper_threshold_q;
   logic [15:0]       lower_threshold_q;
   logic [15:0]       setpoint_q;
   logic [15:0]       cvd_q;
   logic [15:0]       filtered_result_q;
   logic [15:0]       prev_result_q;
   logic [15:0]       prev_flt_q;
   logic [15:0]       latched_q;
   logic [15:0]       err_q;
   logic              sum_wrap_flag_q;
   logic              above_upper_flag_q;
   logic              below_lower_flag_q;
   logic              threshold_irq_flag_q;

   // Sequencing and bus handshake
   logic [2:0]        clr_cnt_q;
   logic              ack_q;
   logic              go_q;
   logic              conv_busy_q;

   // Combinational terms
   logic              wr;
   logic              rd;
   logic              accum_mode;
   logic [23:0]       res_ext;
   logic [23:0]       sum_d;
   logic [23:0]       sum_sh;
   logic [23:0]       sum_lpf_sh;
   logic [15:0]       flt_d;
   logic [15:0]       cnt_d;
   logic              cnt_reached;
   logic              do_compare;
   logic signed [15:0] err_d;
   logic              above;
   logic              below;
   logic              cond;

   // Writes land on the edge at which the master sees waitrequest low
   assign wr = write && ack_q;
   assign rd = read && !ack_q;
   // Modes 101..111 fall back to basic
   assign accum_mode = (compute_mode_q >= arc_pkg::MD_ACCUM) &&
                       (compute_mode_q <= arc_pkg::MD_LPF); // see [R24] [R8]
   assign res_ext = {{(24-RES_W){result[RES_W-1]}}, result}; // see [R1]
   // Shift kept apart so the subtraction below stays arithmetic
   assign sum_lpf_sh = $signed(running_sum_q) >>> shift_amount_q;
   always_comb begin
      sum_d = running_sum_q + res_ext; // see [R2]
      // Low-pass: sum - sum>>shift + new sample, output sum>>shift
      if (compute_mode_q == arc_pkg::MD_LPF) begin
         sum_d = running_sum_q - sum_lpf_sh + res_ext; // see [R12] [R13]
      end
   end
   assign sum_sh = $signed(sum_d) >>> shift_amount_q; // see [R7]
   assign flt_d = sum_sh[15:0];
   assign cnt_d = sample_count_q + 16'h0001; // see [R4]
   assign cnt_reached = cnt_d >= {8'h00, repeat_target_q};
   // Averaging modes compare only once the count has reached one less than the target
   always_comb begin
      do_compare = 1'b1;
      if (compute_mode_q == arc_pkg::MD_AVG ||
          compute_mode_q == arc_pkg::MD_BURST ||
          compute_mode_q == arc_pkg::MD_LPF) begin
         do_compare = cnt_reached; // see [R10]
      end
   end

   // Error source, evaluated on latched values
   always_comb begin
      case (error_source_select_q) // see [R15]
         3'h0: err_d = $signed(latched_q) - $signed(prev_result_q);
         3'h1: err_d = $signed(cvd_q);
         3'h2: err_d = $signed(latched_q) - $signed(setpoint_q);
         3'h3: err_d = $signed(latched_q) - $signed(filtered_result_q);
         3'h4: err_d = $signed(filtered_result_q) - $signed(prev_flt_q);
         3'h5: err_d = $signed(filtered_result_q) - $signed(setpoint_q);
         default: err_d = 16'sh0000;
      endcase
      // Accumulate mode compares the sum itself
      if (compute_mode_q == arc_pkg::MD_ACCUM) begin
         err_d = $signed(running_sum_q[15:0]); // see [R9]
      end
   end
   assign above = err_d > $signed(upper_threshold_q); // see [R16] [R19]
   assign below = err_d < $signed(lower_threshold_q); // see [R19]
   always_comb begin
      case (threshold_mode_select_q) // see [R17] [R23]
         3'h0: cond = 1'b0;
         3'h1: cond = below;
         3'h2: cond = !below;
         3'h3: cond = !below && !above;
         3'h4: cond = below || above;
         3'h5: cond = !above;
         3'h6: cond = above;
         default: cond = 1'b1;
      endcase
   end

   // Computation sequence and clear
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= ARC_IDLE;
         clr_cnt_q <= 3'h0;
      end else begin
         case (state_q)
            ARC_IDLE: begin
               // A pending clear goes first; results meanwhile are refused
               if (sum_clear_bit_q) begin
                  state_q <= ARC_CLEAR;
                  clr_cnt_q <= 3'(arc_pkg::CLR_CYCLES - 1);
               end else if (result_valid) begin
                  state_q <= ARC_CALC;
               end
            end
            ARC_CALC: state_q <= ARC_IDLE;
            ARC_CLEAR: begin
               if (clr_cnt_q == 3'h0) begin
                  state_q <= ARC_IDLE; // see [R6]
               end else begin
                  clr_cnt_q <= clr_cnt_q - 3'h1;
               end
            end
            default: state_q <= ARC_IDLE;
         endcase
      end
   end

   // Datapath
   always_ff @(posedge clock) begin
      if (reset) begin
         running_sum_q <= 24'h000000;
         sample_count_q <= 16'h0000;
         filtered_result_q <= 16'h0000;
         prev_flt_q <= 16'h0000;
         latched_q <= 16'h0000;
         prev_result_q <= 16'h0000;
      end else if (state_q == ARC_CLEAR) begin
         running_sum_q <= 24'h000000; // see [R5]
         sample_count_q <= 16'h0000;
      end else if (state_q == ARC_IDLE && result_valid &&
                   !sum_clear_bit_q) begin
         prev_result_q <= latched_q;
         latched_q <= result; // see [R14]
         if (accum_mode) begin
            running_sum_q <= sum_d; // see [R2] [R9]
            sample_count_q <= cnt_d; // see [R4] [R12]
            prev_flt_q <= filtered_result_q;
            filtered_result_q <= flt_d; // see [R7]
         end
      end else if (wr && address == arc_pkg::A_SUMU) begin
         running_sum_q <= {{6{writedata[1]}}, writedata[1:0],
                           running_sum_q[15:0]}; // see [R21]
      end else if (wr && address == arc_pkg::A_SUMH) begin
         running_sum_q[15:8] <= writedata[7:0];
      end else if (wr && address == arc_pkg::A_SUML) begin
         running_sum_q[7:0] <= writedata[7:0];
      end else if (wr && address == arc_pkg::A_CNT) begin
         sample_count_q <= writedata[15:0];
      end
   end

   // Flags: hardware set wins over software clear
   always_ff @(posedge clock) begin
      if (reset) begin
         sum_wrap_flag_q <= 1'b0;
         above_upper_flag_q <= 1'b0;
         below_lower_flag_q <= 1'b0;
         threshold_irq_flag_q <= 1'b0;
         err_q <= 16'h0000;
      end else begin
         if (state_q == ARC_CLEAR) begin
            sum_wrap_flag_q <= 1'b0; // see [R5]
         end
         if (wr && address == arc_pkg::A_STAT) begin
            if (writedata[0]) threshold_irq_flag_q <= 1'b0;
         end
         if (state_q == ARC_CALC) begin
            // Tested on the sum after this sample's add has landed
            if (accum_mode && $signed(running_sum_q) >
                $signed(arc_pkg::SUM_LIMIT)) begin
               sum_wrap_flag_q <= 1'b1; // see [R3]
               threshold_irq_flag_q <= 1'b1; // see [R20]
            end
            if (do_compare) begin
               err_q <= err_d;
               above_upper_flag_q <= above; // see [R16]
               below_lower_flag_q <= below;
               if (cond) threshold_irq_flag_q <= 1'b1; // see [R18]
            end
         end
      end
   end

   // Clear request: software sets it, the end of the clear drops it
   always_ff @(posedge clock) begin
      if (reset) begin
         sum_clear_bit_q <= 1'b0;
      end else if (state_q == ARC_CLEAR && clr_cnt_q == 3'h0) begin
         sum_clear_bit_q <= 1'b0; // see [R5]
      end else if (wr && address == arc_pkg::A_CTRL2 &&
                   writedata[arc_pkg::CLR_BIT]) begin
         sum_clear_bit_q <= 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge clock) begin
      if (reset) begin
         compute_mode_q <= 3'h0;
         shift_amount_q <= 3'h0;
         cont_q <= 1'b0;
         error_source_select_q <= 3'h0;
         threshold_mode_select_q <= 3'h0;
         repeat_target_q <= 8'h00;
         upper_threshold_q <= 16'h0000;
         lower_threshold_q <= 16'h0000;
         setpoint_q <= 16'h0000;
         cvd_q <= 16'h0000;
      end else begin
         if (wr) begin
            case (address)
               arc_pkg::A_CTRL2: begin
                  compute_mode_q <= writedata[2:0];
                  shift_amount_q <= writedata[6:4];
                  cont_q <= writedata[9];
               end
               arc_pkg::A_CTRL3: begin
                  error_source_select_q <= writedata[6:4];
                  threshold_mode_select_q <= writedata[2:0];
               end
               arc_pkg::A_RPT: repeat_target_q <= writedata[7:0];
               arc_pkg::A_UTH: upper_threshold_q <= writedata[15:0];
               arc_pkg::A_LTH: lower_threshold_q <= writedata[15:0];
               arc_pkg::A_SETP: setpoint_q <= writedata[15:0];
               arc_pkg::A_CVD: cvd_q <= writedata[15:0];
               default: ;
            endcase
         end
      end
   end

   // Conversion start: software go, external trigger, burst/continuous
   always_ff @(posedge clock) begin
      if (reset) begin
         go_q <= 1'b0;
         conv_start <= 1'b0;
         conv_busy_q <= 1'b0;
      end else begin
         go_q <= wr && address == arc_pkg::A_CTRL2 &&
                 writedata[arc_pkg::GO_BIT];
         conv_start <= 1'b0;
         // Busy holds off a burst retrigger until the last result returns
         if (result_valid) conv_busy_q <= 1'b0;
         if (go_q || ext_trigger) begin
            conv_start <= 1'b1; // see [R2]
            conv_busy_q <= 1'b1;
         end else if (state_q == ARC_CALC && !conv_busy_q &&
                      (cont_q || (compute_mode_q == arc_pkg::MD_BURST &&
                       sample_count_q < {8'h00, repeat_target_q}))) begin
            conv_start <= 1'b1; // see [R11]
            conv_busy_q <= 1'b1;
         end
      end
   end

   // Avalon slave: one wait cycle, answer on the second
   always_ff @(posedge clock) begin
      if (reset) ack_q <= 1'b0;
      else ack_q <= (read || write) && !ack_q;
   end

   always_ff @(posedge clock) begin
      if (reset) threshold_irq <= 1'b0;
      else threshold_irq <= threshold_irq_flag_q;
   end

   // Read data is captured on the first edge and stands at the second
   always_ff @(posedge clock) begin
      if (reset) begin
         readdata <= 32'h00000000;
      end else begin
         if (rd) begin
            case (address)
               arc_pkg::A_CTRL2: readdata <= {22'h0, cont_q, 1'b0,
                  sum_clear_bit_q, shift_amount_q, 1'b0, compute_mode_q};
               arc_pkg::A_CTRL3: readdata <= {25'h0,
                  error_source_select_q, 1'b0, threshold_mode_select_q};
               arc_pkg::A_STAT: readdata <= {28'h0, sum_wrap_flag_q,
                  above_upper_flag_q, below_lower_flag_q,
                  threshold_irq_flag_q};
               arc_pkg::A_RPT: readdata <= {24'h0, repeat_target_q};
               arc_pkg::A_CNT: readdata <= {16'h0, sample_count_q};
               arc_pkg::A_SUMU: readdata <= {30'h0, running_sum_q[17:16]};
               arc_pkg::A_SUMH: readdata <= {24'h0, running_sum_q[15:8]};
               arc_pkg::A_SUML: readdata <= {24'h0, running_sum_q[7:0]};
               arc_pkg::A_FLT: readdata <= {16'h0, filtered_result_q};
               arc_pkg::A_UTH: readdata <= {16'h0, upper_threshold_q};
               arc_pkg::A_LTH: readdata <= {16'h0, lower_threshold_q};
               arc_pkg::A_SETP: readdata <= {16'h0, setpoint_q};
               arc_pkg::A_ERR: readdata <= {16'h0, err_q};
               arc_pkg::A_CVD: readdata <= {16'h0, cvd_q};
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end
   always_ff @(posedge clock) begin
      if (reset) waitrequest <= 1'b1;
      else waitrequest <= !((read || write) && !ack_q);
   end
endmodule : arc_unit
`default_nettype wire

// ### bench/arc_unit_props.sv
// Port-level assertions for the result computation unit
`timescale 1ns/1ps
`default_nettype none
module arc_unit_props (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        result_valid,
   input wire logic        conv_start,
   input wire logic        threshold_irq
);
   logic [2:0] thmode_q;
   logic       irq_clr_q;
   // A status clear lands on the answering edge; the pin drops one later
   always_ff @(posedge clock) begin
      if (reset) irq_clr_q <= 1'b0;
      else irq_clr_q <= write && !waitrequest &&
         address == arc_pkg::A_STAT && writedata[0];
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         thmode_q <= 3'h0;
      end else if (write && !waitrequest && address == arc_pkg::A_CTRL3) begin
         thmode_q <= writedata[2:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   bus_answer_a: assert property (($rose(read) || $rose(write))
      |=> !waitrequest)
      else $error("bus request not answered in one cycle");
   ack_single_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   ack_cause_a: assert property (!waitrequest |-> (read || write))
      else $error("waitrequest low without a request");
   read_hold_a: assert property (!read |=> $stable(readdata))
      else $error("read data changed without a read");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   go_start_a: assert property (($rose(write)
      && address == arc_pkg::A_CTRL2 && writedata[arc_pkg::GO_BIT])
      |-> ##[1:4] conv_start)
      else $error("software start gave no conversion start");
   irq_always_a: assert property ((thmode_q == 3'h7
      && result_valid) |-> ##[1:6] threshold_irq)
      else $error("always mode raised no interrupt");
   irq_sticky_a: assert property ((threshold_irq
      && !irq_clr_q) |=> threshold_irq)
      else $error("interrupt flag dropped without a clear");
   cover property ($rose(threshold_irq));
   cover property (conv_start);
   cover property (read && !waitrequest);
endmodule : arc_unit_props
bind arc_unit arc_unit_props u_props (.clock(clock), .reset(reset),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest),
   .result_valid(result_valid), .conv_start(conv_start),
   .threshold_irq(threshold_irq));
`default_nettype wire

// ### bench/arc_unit_tb.sv
// Self-checking bench for the result computation unit
`timescale 1ns/1ps
`default_nettype none
module arc_unit_tb;
   logic        clock;
   logic        reset;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        result_valid;
   logic [15:0] result;
   logic        ext_trigger;
   logic        conv_start;
   logic        threshold_irq;
   logic        auto;
   logic [31:0] rd;
   int          failures;
   int          compares;
   int          cycles;
   int          starts;

   arc_unit DUT (.clock(clock), .reset(reset), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .result_valid(result_valid), .result(result),
      .ext_trigger(ext_trigger), .conv_start(conv_start),
      .threshold_irq(threshold_irq));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input string what, input logic [3:0] a,
                        input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rdchk

   task automatic sample(input logic [15:0] v);
      @(posedge clock);
      result <= v;
      result_valid <= 1'b1;
      @(posedge clock);
      result_valid <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : sample

   task automatic clear_sum;
      wr(arc_pkg::A_CTRL2, 32'h1 << arc_pkg::CLR_BIT);
      rd = 32'h80;
      while (rd[7] === 1'b1) bus(1'b0, arc_pkg::A_CTRL2, 32'h0);
      rdchk("sum low", arc_pkg::A_SUML, 32'h0);
      rdchk("count", arc_pkg::A_CNT, 32'h0);
      bus(1'b0, arc_pkg::A_STAT, 32'h0);
      chk("wrap flag", rd & 32'h8, 32'h0);
   endtask : clear_sum

   task automatic t_regs;
      wr(arc_pkg::A_UTH, 32'h1234);
      rdchk("upper thr", arc_pkg::A_UTH, 32'h1234);
      wr(arc_pkg::A_SUMU, 32'hff);
      rdchk("sum upper", arc_pkg::A_SUMU, 32'h3);
      wr(arc_pkg::A_SUML, 32'ha5);
      rdchk("sum low", arc_pkg::A_SUML, 32'ha5);
      wr(4'hf, 32'hffff);
      rdchk("unmapped", 4'hf, 32'h0);
      $display("test regs done");
   endtask : t_regs

   // Extreme signed limits make every condition independent of the error
   task automatic t_thr;
      clear_sum();
      wr(arc_pkg::A_UTH, 32'h7fff);
      wr(arc_pkg::A_LTH, 32'h8000);
      for (int m = 0; m < 8; m++) begin
         wr(arc_pkg::A_CTRL3, 32'(m));
         wr(arc_pkg::A_STAT, 32'h1);
         sample(16'h0100);
         chk("irq", {31'h0, threshold_irq}, 32'((8'hac >> m) & 8'h01));
         rdchk("status", arc_pkg::A_STAT, 32'((8'hac >> m) & 8'h01));
      end
      $display("test threshold done");
   endtask : t_thr

   task automatic t_acc;
      clear_sum();
      wr(arc_pkg::A_CTRL2, 32'h11);
      sample(16'h0010);
      sample(16'h0020);
      sample(16'hfff0);
      rdchk("count", arc_pkg::A_CNT, 32'h3);
      rdchk("sum low", arc_pkg::A_SUML, 32'h20);
      rdchk("filtered", arc_pkg::A_FLT, 32'h10);
      sample(16'hffc0);
      rdchk("sum upper", arc_pkg::A_SUMU, 32'h3);
      rdchk("sum mid", arc_pkg::A_SUMH, 32'hff);
      rdchk("filtered", arc_pkg::A_FLT, 32'hfff0);
      clear_sum();
      wr(arc_pkg::A_CTRL2, 32'h5);
      sample(16'h0010);
      rdchk("count", arc_pkg::A_CNT, 32'h0);
      // Sum starts at 131071; the fifth large sample passes the limit
      wr(arc_pkg::A_CTRL3, 32'h0);
      wr(arc_pkg::A_STAT, 32'h1);
      wr(arc_pkg::A_CTRL2, 32'h1);
      wr(arc_pkg::A_SUMU, 32'h1);
      wr(arc_pkg::A_SUMH, 32'hff);
      wr(arc_pkg::A_SUML, 32'hff);
      repeat (5) sample(16'h7fff);
      rdchk("wrap status", arc_pkg::A_STAT, 32'h9);
      clear_sum();
      $display("test accumulate done");
   endtask : t_acc

   task automatic t_burst;
      int s0;
      clear_sum();
      wr(arc_pkg::A_RPT, 32'h4);
      auto <= 1'b1;
      s0 = starts;
      wr(arc_pkg::A_CTRL2, 32'h123);
      repeat (100) @(posedge clock);
      auto <= 1'b0;
      chk("starts", 32'(starts - s0), 32'h4);
      rdchk("count", arc_pkg::A_CNT, 32'h4);
      rdchk("filtered", arc_pkg::A_FLT, 32'h8);
      wr(arc_pkg::A_CTRL2, 32'h24);
      sample(16'h0008);
      rdchk("count", arc_pkg::A_CNT, 32'h5);
      s0 = starts;
      @(posedge clock);
      ext_trigger <= 1'b1;
      @(posedge clock);
      ext_trigger <= 1'b0;
      repeat (3) @(posedge clock);
      chk("ext starts", 32'(starts - s0), 32'h1);
      $display("test burst done");
   endtask : t_burst

   // Converter stand-in answers each start one cycle later
   always @(posedge clock) begin
      if (conv_start === 1'b1) starts <= starts + 1;
      if (auto) begin
         result_valid <= (conv_start === 1'b1);
         result <= 16'h0008;
      end
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   initial begin
      reset = 1'b1;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      result_valid = 1'b0;
      result = 16'h0;
      ext_trigger = 1'b0;
      auto = 1'b0;
      failures = 0;
      compares = 0;
      cycles = 0;
      starts = 0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      t_regs();
      t_thr();
      t_acc();
      t_burst();
      close_out();
   end
endmodule : arc_unit_tb
`default_nettype wire
